// ---- logic/cfsr_regs.vh ----
`ifndef CFSR_REGS_VH
`define CFSR_REGS_VH

// Condition flag bit positions
`define CFSR_CC_HALF       4
`define CFSR_CC_MASK       3
`define CFSR_CC_NEG        2
`define CFSR_CC_ZERO       1
`define CFSR_CC_CARRY      0
`define CFSR_CC_ONES       3'h7
`define CFSR_CC_RESET      8'he8

// Stack pointer layout and reset value
`define CFSR_SP_RESET      16'h017f
`define CFSR_SP_HIGH       9'h002
`define CFSR_SP_LOW_RESET  7'h7f
`define CFSR_SP_ONE        7'h01
`define CFSR_SP_BITS       7
`define CFSR_STACK_DEPTH   128

// Command codes
`define CFSR_CMD_NOP       5'h00
`define CFSR_CMD_LD_A      5'h01
`define CFSR_CMD_LD_X      5'h02
`define CFSR_CMD_LD_Y      5'h03
`define CFSR_CMD_ADD       5'h04
`define CFSR_CMD_ADC       5'h05
`define CFSR_CMD_SUB       5'h06
`define CFSR_CMD_LOGIC     5'h07
`define CFSR_CMD_SHL       5'h08
`define CFSR_CMD_SHR       5'h09
`define CFSR_CMD_RLC       5'h0a
`define CFSR_CMD_RRC       5'h0b
`define CFSR_CMD_BTEST     5'h0c
`define CFSR_CMD_SETC      5'h0d
`define CFSR_CMD_CLRC      5'h0e
`define CFSR_CMD_SIM       5'h0f
`define CFSR_CMD_RIM       5'h10
`define CFSR_CMD_LD_CC     5'h11
`define CFSR_CMD_LD_S      5'h12
`define CFSR_CMD_SPRST     5'h13
`define CFSR_CMD_JUMP      5'h14
`define CFSR_CMD_CALL      5'h15
`define CFSR_CMD_RET       5'h16
`define CFSR_CMD_PUSH      5'h17
`define CFSR_CMD_POP       5'h18
`define CFSR_CMD_RETI      5'h19
`define CFSR_CMD_TRAP      5'h1a

// Stack sequence kinds
`define CFSR_KIND_INT      2'h0
`define CFSR_KIND_CALL     2'h1
`define CFSR_KIND_BYTE     2'h2

// Byte counts of stack sequences, stored as last index
`define CFSR_LAST_INT      3'h4
`define CFSR_LAST_CALL     3'h1
`define CFSR_LAST_BYTE     3'h0
`define CFSR_IDX_ZERO      3'h0
`define CFSR_IDX_ONE       3'h1
`define CFSR_IDX_TWO       3'h2
`define CFSR_IDX_THREE     3'h3

// Bit test select field inside the command data
`define CFSR_BSEL_HI       10
`define CFSR_BSEL_LO       8

`endif

// ---- logic/cfsr_stack_ram.v ----
`include "cfsr_regs.vh"

// Stack memory, one write port and one registered read port
module cfsr_stack_ram (
  input  wire                     core_clk,
  input  wire                     wr_en,
  input  wire [`CFSR_SP_BITS-1:0] wr_addr,
  input  wire [7:0]               wr_data,
  input  wire [`CFSR_SP_BITS-1:0] rd_addr,
  output reg  [7:0]               rd_data_q
);

  reg [7:0] mem [0:`CFSR_STACK_DEPTH-1];

  // Read data lags the address by one cycle; the pop sequence allows for it
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule

// ---- logic/cfsr_core.v ----
// Function
// (RULE1) One 8-bit accumulator holds operands and results of arithmetic and logic.
// (RULE2) Interrupt stacking never saves or restores the second index register.
// (RULE3) Instruction address is 16 bits, built from a low and a high byte.
// (RULE4) Flag register upper three bits are ones; mask bit is one after reset.
// (RULE5) Half carry follows the carry out of bit 3 on add operations.
// (RULE6) Mask set on interrupt entry or by software; cleared by software or return.
// (RULE7) Masked requests stay pending and are serviced once the mask clears.
// (RULE8) Negative flag copies result bit 7 after every data operation.
// (RULE9) Zero flag is set when the last data operation result is zero.
// (RULE10) Carry shows overflow; set, reset, bit test, shift and rotate update it.
// (RULE11) Reset or stack pointer reset command loads 017F hex.
// (RULE12) Stack pointer points at next free byte: post-decrement push, pre-increment pop.
// (RULE13) Stack is 128 bytes; upper nine pointer bits are fixed by hardware.
// (RULE14) Pointer wraps silently on overflow and underflow, with no indication.
// (RULE15) Interrupt entry writes the low address byte first, then lower addresses.
// (RULE16) A call uses two stack bytes and an interrupt entry five.
// (RULE17) The pointer low byte is loaded directly by a load command.
// (RULE18) Interrupt entry saves address, first index, accumulator and flags.
// (RULE19) Writes to the upper three flag bits are ignored; they read as one.
`include "cfsr_regs.vh"

module cfsr_core (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        cmd_valid,
  input  wire [4:0]  cmd_code,
  input  wire [15:0] cmd_data,
  input  wire        irq_req,
  input  wire [15:0] irq_vector,
  output reg         cmd_ready_q,
  output reg  [7:0]  acc_q,
  output reg  [7:0]  x_q,
  output reg  [7:0]  y_q,
  output reg  [15:0] pc_q,
  output reg  [7:0]  cc_q,
  output reg  [15:0] sp_q,
  output reg  [7:0]  pop_data_q,
  output reg         pop_valid_q,
  output reg         irq_ack_q,
  output reg         irq_pend_q
);

  // One-hot sequencer states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PUSH = 4'h2;
  localparam [3:0] ST_POPA = 4'h4;
  localparam [3:0] ST_POPD = 4'h8;

  reg  [3:0]               state_q;
  reg  [3:0]               state_d;
  reg  [1:0]               kind_q;
  reg  [1:0]               kind_d;
  reg  [2:0]               idx_q;
  reg  [2:0]               idx_d;
  reg  [2:0]               last_q;
  reg  [2:0]               last_d;
  reg                      is_reti_q;
  reg                      is_reti_d;
  reg  [15:0]              tgt_q;
  reg  [15:0]              tgt_d;
  reg  [7:0]               acc_d;
  reg  [7:0]               x_d;
  reg  [7:0]               y_d;
  reg  [15:0]              pc_d;
  reg  [7:0]               cc_d;
  reg  [`CFSR_SP_BITS-1:0] sp_lo_d;
  reg  [7:0]               pop_data_d;
  reg                      pop_valid_d;
  reg                      irq_ack_d;
  reg                      irq_pend_d;
  reg                      cmd_ready_d;
  reg                      ram_we;
  reg  [7:0]               ram_wdata;
  reg  [8:0]               sum;
  reg  [4:0]               nib;
  reg  [7:0]               res;
  reg                      upd_nz;
  reg                      start_irq;
  reg                      take_cmd;

  wire [`CFSR_SP_BITS-1:0] sp_lo = sp_q[`CFSR_SP_BITS-1:0];
  wire [`CFSR_SP_BITS-1:0] sp_inc = sp_lo + `CFSR_SP_ONE;
  wire [`CFSR_SP_BITS-1:0] sp_dec = sp_lo - `CFSR_SP_ONE;
  wire [7:0]               ram_rdata;
  wire                     cin = cc_q[`CFSR_CC_CARRY];

  // Pop address is always one above the pointer, since pops pre-increment
  cfsr_stack_ram u_ram (
    .core_clk  (core_clk),
    .wr_en     (ram_we),
    .wr_addr   (sp_lo),
    .wr_data   (ram_wdata),
    .rd_addr   (sp_inc),
    .rd_data_q (ram_rdata)
  );

  // Byte pushed at each step: low address byte first, second index never stacked
  always @* begin
    ram_wdata = tgt_q[7:0];
    if (kind_q == `CFSR_KIND_BYTE) begin
      ram_wdata = tgt_q[7:0];
    end else begin
      case (idx_q)
        `CFSR_IDX_ZERO:  ram_wdata = pc_q[7:0];   // [RULE15]
        `CFSR_IDX_ONE:   ram_wdata = pc_q[15:8];
        `CFSR_IDX_TWO:   ram_wdata = x_q;         // [RULE2] [RULE18]
        `CFSR_IDX_THREE: ram_wdata = acc_q;
        default:         ram_wdata = cc_q;
      endcase
    end
  end

  // Next-state logic of the whole register set
  always @* begin
    state_d     = state_q;
    kind_d      = kind_q;
    idx_d       = idx_q;
    last_d      = last_q;
    is_reti_d   = is_reti_q;
    tgt_d       = tgt_q;
    acc_d       = acc_q;
    x_d         = x_q;
    y_d         = y_q;
    pc_d        = pc_q;
    cc_d        = cc_q;
    sp_lo_d     = sp_lo;
    pop_data_d  = pop_data_q;
    pop_valid_d = 1'b0;
    irq_ack_d   = 1'b0;
    ram_we      = 1'b0;
    sum         = 9'h000;
    nib         = 5'h00;
    res         = acc_q;
    upd_nz      = 1'b0;
    take_cmd    = 1'b0;
    start_irq   = 1'b0;

    case (state_q)
      ST_IDLE: begin
        if (cmd_ready_q && cmd_valid) begin
          take_cmd = 1'b1;
        end else if (cmd_ready_q && irq_pend_q && !cc_q[`CFSR_CC_MASK]) begin
          start_irq = 1'b1;  // [RULE7]
        end
      end
      ST_PUSH: begin
        // Post-decrement push; 7-bit arithmetic wraps silently
        ram_we  = 1'b1;
        sp_lo_d = sp_dec;  // [RULE12] [RULE14]
        idx_d   = idx_q + `CFSR_IDX_ONE;
        if (idx_q == last_q) begin
          state_d = ST_IDLE;
          if (kind_q == `CFSR_KIND_INT) begin
            cc_d[`CFSR_CC_MASK] = 1'b1;  // [RULE6]
            pc_d = tgt_q;
          end else if (kind_q == `CFSR_KIND_CALL) begin
            pc_d = tgt_q;
          end
        end
      end
      ST_POPA: begin
        // Pre-increment pop; the memory sees the new address this cycle
        sp_lo_d = sp_inc;  // [RULE12] [RULE14]
        state_d = ST_POPD;
      end
      ST_POPD: begin
        idx_d   = idx_q + `CFSR_IDX_ONE;
        state_d = (idx_q == last_q) ? ST_IDLE : ST_POPA;
        if (kind_q == `CFSR_KIND_BYTE) begin
          pop_data_d  = ram_rdata;
          pop_valid_d = 1'b1;
        end else if (kind_q == `CFSR_KIND_CALL) begin
          if (idx_q == `CFSR_IDX_ZERO) begin
            pc_d[15:8] = ram_rdata;
          end else begin
            pc_d[7:0] = ram_rdata;
          end
        end else begin
          // Return from interrupt unwinds flags, accumulator, index, address
          case (idx_q)
            `CFSR_IDX_ZERO:  cc_d = {`CFSR_CC_ONES, ram_rdata[4:0]};  // [RULE19]
            `CFSR_IDX_ONE:   acc_d = ram_rdata;
            `CFSR_IDX_TWO:   x_d = ram_rdata;  // [RULE2]
            `CFSR_IDX_THREE: pc_d[15:8] = ram_rdata;
            default:         pc_d[7:0] = ram_rdata;
          endcase
        end
        if (idx_q == last_q && is_reti_q) begin
          cc_d[`CFSR_CC_MASK] = 1'b0;  // [RULE6]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Hardware interrupt entry: five bytes, vector loaded at the end
    if (start_irq) begin
      state_d   = ST_PUSH;
      kind_d    = `CFSR_KIND_INT;
      idx_d     = `CFSR_IDX_ZERO;
      last_d    = `CFSR_LAST_INT;  // [RULE16]
      tgt_d     = irq_vector;
      irq_ack_d = 1'b1;
    end

    if (take_cmd) begin
      idx_d     = `CFSR_IDX_ZERO;
      is_reti_d = 1'b0;
      case (cmd_code)
        `CFSR_CMD_LD_A: begin
          acc_d  = cmd_data[7:0];  // [RULE1]
          res    = cmd_data[7:0];
          upd_nz = 1'b1;
        end
        `CFSR_CMD_LD_X: begin
          x_d    = cmd_data[7:0];
          res    = cmd_data[7:0];
          upd_nz = 1'b1;
        end
        `CFSR_CMD_LD_Y: begin
          y_d    = cmd_data[7:0];
          res    = cmd_data[7:0];
          upd_nz = 1'b1;
        end
        `CFSR_CMD_ADD, `CFSR_CMD_ADC: begin
          // Carry in only for add-with-carry
          sum = {1'b0, acc_q} + {1'b0, cmd_data[7:0]} +
                {8'h00, (cmd_code == `CFSR_CMD_ADC) & cin};
          nib = {1'b0, acc_q[3:0]} + {1'b0, cmd_data[3:0]} +
                {4'h0, (cmd_code == `CFSR_CMD_ADC) & cin};
          res    = sum[7:0];
          acc_d  = sum[7:0];
          cc_d[`CFSR_CC_HALF]  = nib[4];  // [RULE5]
          cc_d[`CFSR_CC_CARRY] = sum[8];  // [RULE10]
          upd_nz = 1'b1;
        end
        `CFSR_CMD_SUB: begin
          // Borrow shows in the ninth bit of the difference
          sum    = {1'b0, acc_q} - {1'b0, cmd_data[7:0]};
          res    = sum[7:0];
          acc_d  = sum[7:0];
          cc_d[`CFSR_CC_CARRY] = sum[8];  // [RULE10]
          upd_nz = 1'b1;
        end
        `CFSR_CMD_LOGIC: begin
          // Logic unit result arrives ready-made on the data lines
          acc_d  = cmd_data[7:0];
          res    = cmd_data[7:0];
          upd_nz = 1'b1;
        end
        `CFSR_CMD_SHL, `CFSR_CMD_RLC: begin
          res    = {acc_q[6:0], (cmd_code == `CFSR_CMD_RLC) & cin};
          acc_d  = res;
          cc_d[`CFSR_CC_CARRY] = acc_q[7];  // [RULE10]
          upd_nz = 1'b1;
        end
        `CFSR_CMD_SHR, `CFSR_CMD_RRC: begin
          res    = {(cmd_code == `CFSR_CMD_RRC) & cin, acc_q[7:1]};
          acc_d  = res;
          cc_d[`CFSR_CC_CARRY] = acc_q[0];  // [RULE10]
          upd_nz = 1'b1;
        end
        `CFSR_CMD_BTEST: begin
          cc_d[`CFSR_CC_CARRY] = cmd_data[cmd_data[`CFSR_BSEL_HI:`CFSR_BSEL_LO]];  // [RULE10]
        end
        `CFSR_CMD_SETC: begin
          cc_d[`CFSR_CC_CARRY] = 1'b1;  // [RULE10]
        end
        `CFSR_CMD_CLRC: begin
          cc_d[`CFSR_CC_CARRY] = 1'b0;  // [RULE10]
        end
        `CFSR_CMD_SIM: begin
          cc_d[`CFSR_CC_MASK] = 1'b1;  // [RULE6]
        end
        `CFSR_CMD_RIM: begin
          cc_d[`CFSR_CC_MASK] = 1'b0;  // [RULE6]
        end
        `CFSR_CMD_LD_CC: begin
          cc_d = {`CFSR_CC_ONES, cmd_data[4:0]};  // [RULE19]
        end
        `CFSR_CMD_LD_S: begin
          sp_lo_d = cmd_data[`CFSR_SP_BITS-1:0];  // [RULE17] [RULE13]
        end
        `CFSR_CMD_SPRST: begin
          sp_lo_d = `CFSR_SP_LOW_RESET;  // [RULE11]
        end
        `CFSR_CMD_JUMP: begin
          pc_d = cmd_data;  // [RULE3]
        end
        `CFSR_CMD_CALL: begin
          state_d = ST_PUSH;
          kind_d  = `CFSR_KIND_CALL;
          last_d  = `CFSR_LAST_CALL;  // [RULE16]
          tgt_d   = cmd_data;
        end
        `CFSR_CMD_TRAP: begin
          // Software trap ignores the mask
          state_d = ST_PUSH;
          kind_d  = `CFSR_KIND_INT;
          last_d  = `CFSR_LAST_INT;  // [RULE16] [RULE6]
          tgt_d   = cmd_data;
        end
        `CFSR_CMD_RET: begin
          state_d = ST_POPA;
          kind_d  = `CFSR_KIND_CALL;
          last_d  = `CFSR_LAST_CALL;
        end
        `CFSR_CMD_RETI: begin
          state_d   = ST_POPA;
          kind_d    = `CFSR_KIND_INT;
          last_d    = `CFSR_LAST_INT;
          is_reti_d = 1'b1;
        end
        `CFSR_CMD_PUSH: begin
          state_d = ST_PUSH;
          kind_d  = `CFSR_KIND_BYTE;
          last_d  = `CFSR_LAST_BYTE;
          tgt_d   = cmd_data;
        end
        `CFSR_CMD_POP: begin
          state_d = ST_POPA;
          kind_d  = `CFSR_KIND_BYTE;
          last_d  = `CFSR_LAST_BYTE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end

    // Sign and zero taken from the result of the data operation
    if (upd_nz) begin
      cc_d[`CFSR_CC_NEG]  = res[7];           // [RULE8]
      cc_d[`CFSR_CC_ZERO] = (res == 8'h00);   // [RULE9]
    end

    // A new request in the service cycle wins over the clear
    irq_pend_d  = irq_req | (irq_pend_q & ~start_irq);  // [RULE7]
    cmd_ready_d = (state_d == ST_IDLE) && !start_irq && !take_cmd;
  end

  // All state on one clock; reset is synchronous
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      kind_q      <= `CFSR_KIND_BYTE;
      idx_q       <= `CFSR_IDX_ZERO;
      last_q      <= `CFSR_LAST_BYTE;
      is_reti_q   <= 1'b0;
      tgt_q       <= 16'h0000;
      acc_q       <= 8'h00;
      x_q         <= 8'h00;
      y_q         <= 8'h00;
      pc_q        <= 16'h0000;
      cc_q        <= `CFSR_CC_RESET;  // [RULE4]
      sp_q        <= `CFSR_SP_RESET;  // [RULE11]
      pop_data_q  <= 8'h00;
      pop_valid_q <= 1'b0;
      irq_ack_q   <= 1'b0;
      irq_pend_q  <= 1'b0;
      cmd_ready_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      kind_q      <= kind_d;
      idx_q       <= idx_d;
      last_q      <= last_d;
      is_reti_q   <= is_reti_d;
      tgt_q       <= tgt_d;
      acc_q       <= acc_d;
      x_q         <= x_d;
      y_q         <= y_d;
      pc_q        <= pc_d;
      cc_q        <= {`CFSR_CC_ONES, cc_d[4:0]};  // [RULE4] [RULE19]
      sp_q        <= {`CFSR_SP_HIGH, sp_lo_d};    // [RULE13]
      pop_data_q  <= pop_data_d;
      pop_valid_q <= pop_valid_d;
      irq_ack_q   <= irq_ack_d;
      irq_pend_q  <= irq_pend_d;
      cmd_ready_q <= cmd_ready_d;
    end
  end

endmodule

// ---- test/cfsr_core_asserts.sv ----
`include "cfsr_regs.vh"

// Watches the core ports for flag and stack relations
module cfsr_core_asserts (
  input logic        core_clk,
  input logic        rst_n,
  input logic        cmd_valid,
  input logic [4:0]  cmd_code,
  input logic [15:0] cmd_data,
  input logic [15:0] irq_vector,
  input logic        cmd_ready_q,
  input logic [7:0]  acc_q,
  input logic [7:0]  y_q,
  input logic [15:0] pc_q,
  input logic [7:0]  cc_q,
  input logic [15:0] sp_q,
  input logic        irq_ack_q,
  input logic        irq_pend_q
);
  timeunit 1ns;
  timeprecision 1ns;

  wire [4:0] half_sum;
  wire       half_c;

  // Low nibble sum as the adder sees it; carry in only for add with carry
  assign half_sum = {1'b0, acc_q[3:0]} + {1'b0, cmd_data[3:0]} + {4'h0, (cmd_code == `CFSR_CMD_ADC) & cc_q[0]};
  assign half_c   = half_sum[4];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A command accepted at this edge
  sequence s_take(logic [4:0] code);
    cmd_valid && cmd_ready_q && cmd_code == code;
  endsequence

  // Edge at which the core starts servicing a pending request
  sequence s_serv;
    cmd_ready_q && !cmd_valid && irq_pend_q && !cc_q[3];
  endsequence

  a_cc_upper_ones: assert property (cc_q[7:5] == `CFSR_CC_ONES)
    else $error("flag register upper bits not all ones");
  a_sp_upper_fixed: assert property (sp_q[15:7] == `CFSR_SP_HIGH)
    else $error("stack pointer upper bits not fixed");
  a_reset_state: assert property (
    $rose(rst_n) |-> cc_q == `CFSR_CC_RESET && sp_q == `CFSR_SP_RESET ##1 cmd_ready_q)
    else $error("wrong state after reset");
  a_push_one_byte: assert property (
    s_take(`CFSR_CMD_PUSH) |-> ##3 sp_q[6:0] + 7'h01 == $past(sp_q[6:0], 3))
    else $error("push did not lower pointer by one");
  a_call_two_bytes: assert property (
    s_take(`CFSR_CMD_CALL) |-> ##4 sp_q[6:0] + 7'h02 == $past(sp_q[6:0], 4) && pc_q == $past(cmd_data, 4))
    else $error("call did not use two bytes");
  a_trap_entry: assert property (
    s_take(`CFSR_CMD_TRAP) |-> ##7 sp_q[6:0] + 7'h05 == $past(sp_q[6:0], 7) && cc_q[3] &&
    pc_q == $past(cmd_data, 7))
    else $error("trap entry wrong");
  a_irq_context_save: assert property (
    s_serv |-> ##1 irq_ack_q ##5 sp_q[6:0] + 7'h05 == $past(sp_q[6:0], 6) &&
    pc_q == $past(irq_vector, 6) && cc_q[3] && y_q == $past(y_q, 6))
    else $error("interrupt entry wrong");
  a_masked_pending: assert property (irq_pend_q && cc_q[3] |=> irq_pend_q)
    else $error("masked request lost");
  a_ack_after_pend: assert property (irq_ack_q |-> $past(irq_pend_q) && !$past(cc_q[3]))
    else $error("service without unmasked pending request");
  a_load_flags: assert property (
    s_take(`CFSR_CMD_LD_A) |=> acc_q == $past(cmd_data[7:0]) && cc_q[2] == acc_q[7] &&
    cc_q[1] == (acc_q == 8'h00))
    else $error("load result or flags wrong");
  a_half_carry: assert property (
    cmd_valid && cmd_ready_q && (cmd_code == `CFSR_CMD_ADD || cmd_code == `CFSR_CMD_ADC) |=>
    cc_q[4] == $past(half_c))
    else $error("half carry wrong");
  a_carry_direct: assert property (
    cmd_valid && cmd_ready_q && (cmd_code == `CFSR_CMD_SETC || cmd_code == `CFSR_CMD_CLRC) |=>
    cc_q[0] == ($past(cmd_code) == `CFSR_CMD_SETC))
    else $error("direct carry write wrong");
  a_sp_reset_cmd: assert property (s_take(`CFSR_CMD_SPRST) |=> sp_q == `CFSR_SP_RESET)
    else $error("pointer reset command wrong");
endmodule

bind cfsr_core cfsr_core_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_data(cmd_data), .irq_vector(irq_vector), .cmd_ready_q(cmd_ready_q),
  .acc_q(acc_q), .y_q(y_q), .pc_q(pc_q), .cc_q(cc_q), .sp_q(sp_q), .irq_ack_q(irq_ack_q), .irq_pend_q(irq_pend_q));

// ---- test/test_cpu_flags_and_stack_regs.sv ----
`include "cfsr_regs.vh"

module test_cpu_flags_and_stack_regs;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [4:0]  code;
    logic [15:0] data;
    logic [7:0]  acc;
    logic [7:0]  cc;
    logic [7:0]  mask;
  } cfsr_row_t;

  logic        core_clk;
  logic        rst_n;
  logic        cmd_valid;
  logic [4:0]  cmd_code;
  logic [15:0] cmd_data;
  logic        irq_req;
  logic [15:0] irq_vector;
  wire         cmd_ready_q, pop_valid_q, irq_ack_q, irq_pend_q;
  wire  [7:0]  acc_q, x_q, y_q, cc_q, pop_data_q;
  wire  [15:0] pc_q, sp_q;
  int          err_total;
  int          num_checks;
  int          i;
  cfsr_row_t   rows [0:19];
  logic [7:0]  ctx [0:4];

  cfsr_core dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .irq_req(irq_req), .irq_vector(irq_vector), .cmd_ready_q(cmd_ready_q),
    .acc_q(acc_q), .x_q(x_q), .y_q(y_q), .pc_q(pc_q), .cc_q(cc_q), .sp_q(sp_q), .pop_data_q(pop_data_q),
    .pop_valid_q(pop_valid_q), .irq_ack_q(irq_ack_q), .irq_pend_q(irq_pend_q));

  // 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic results;
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge, clear of sampling
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // Bounded wait for idle; a hang ends the run as a failure
  task automatic wait_ready;
    int n;
    for (n = 0; n < 40 && cmd_ready_q !== 1'b1; n++) tick();
    if (cmd_ready_q !== 1'b1) begin
      err_total++;
      results();
    end
  endtask

  // Offer one command, hold it until taken, then wait for the core to settle
  task automatic cmd(input logic [4:0] code, input logic [15:0] data);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    tick();
    cmd_valid = 1'b0;
    wait_ready();
  endtask

  initial begin
    err_total  = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    cmd_valid  = 1'b0;
    cmd_code   = 5'h00;
    cmd_data   = 16'h0000;
    irq_req    = 1'b0;
    irq_vector = 16'h4000;
    ctx        = '{8'he0, 8'h33, 8'h11, 8'h24, 8'h68};
    // Flag rows: code, operand, accumulator, flags, flags compared
    rows[0]  = '{`CFSR_CMD_LD_A,  16'h0080, 8'h80, 8'hec, 8'hef};
    rows[1]  = '{`CFSR_CMD_ADD,   16'h008f, 8'h0f, 8'he9, 8'hff};
    rows[2]  = '{`CFSR_CMD_ADC,   16'h0001, 8'h11, 8'hf8, 8'hff};
    rows[3]  = '{`CFSR_CMD_ADD,   16'h0001, 8'h12, 8'he8, 8'hff};
    rows[4]  = '{`CFSR_CMD_SUB,   16'h0012, 8'h00, 8'hea, 8'hef};
    rows[5]  = '{`CFSR_CMD_SUB,   16'h0001, 8'hff, 8'hed, 8'hef};
    rows[6]  = '{`CFSR_CMD_LOGIC, 16'h0000, 8'h00, 8'hea, 8'hee};
    rows[7]  = '{`CFSR_CMD_CLRC,  16'h0000, 8'h00, 8'hea, 8'hef};
    rows[8]  = '{`CFSR_CMD_SETC,  16'h0000, 8'h00, 8'heb, 8'hef};
    rows[9]  = '{`CFSR_CMD_LD_A,  16'h0081, 8'h81, 8'hed, 8'hef};
    rows[10] = '{`CFSR_CMD_SHL,   16'h0000, 8'h02, 8'he9, 8'hef};
    rows[11] = '{`CFSR_CMD_SHR,   16'h0000, 8'h01, 8'he8, 8'hef};
    rows[12] = '{`CFSR_CMD_RRC,   16'h0000, 8'h00, 8'heb, 8'hef};
    rows[13] = '{`CFSR_CMD_RLC,   16'h0000, 8'h01, 8'he8, 8'hef};
    rows[14] = '{`CFSR_CMD_BTEST, 16'h0520, 8'h01, 8'he9, 8'he9};
    rows[15] = '{`CFSR_CMD_BTEST, 16'h0420, 8'h01, 8'he8, 8'he9};
    rows[16] = '{`CFSR_CMD_LD_CC, 16'h0015, 8'h01, 8'hf5, 8'hff};
    rows[17] = '{`CFSR_CMD_SIM,   16'h0000, 8'h01, 8'hfd, 8'hff};
    rows[18] = '{`CFSR_CMD_RIM,   16'h0000, 8'h01, 8'hf5, 8'hff};
    rows[19] = '{`CFSR_CMD_LD_X,  16'h0000, 8'h01, 8'hf3, 8'hef};
    repeat (20) tick();
    rst_n = 1'b1;
    chk8(cc_q, `CFSR_CC_RESET);
    chk16(sp_q, `CFSR_SP_RESET);
    foreach (rows[r]) begin
      cmd(rows[r].code, rows[r].data);
      chk8(acc_q, rows[r].acc);
      chk8(cc_q & rows[r].mask, rows[r].cc & rows[r].mask);
    end
    // Byte push and pop, then the same across the bottom of the stack
    cmd(`CFSR_CMD_SPRST, 16'h0000);
    cmd(`CFSR_CMD_PUSH, 16'h0055);
    chk16(sp_q, 16'h017e);
    cmd(`CFSR_CMD_POP, 16'h0000);
    chk8(pop_data_q, 8'h55);
    cmd(`CFSR_CMD_LD_S, 16'h0080);
    chk16(sp_q, 16'h0100);
    cmd(`CFSR_CMD_PUSH, 16'h00a5);
    chk16(sp_q, 16'h017f);
    cmd(`CFSR_CMD_POP, 16'h0000);
    chk8(pop_data_q, 8'ha5);
    chk16(sp_q, 16'h0100);
    // Call from the bottom wraps too; return restores the address
    cmd(`CFSR_CMD_JUMP, 16'habcd);
    cmd(`CFSR_CMD_CALL, 16'h1234);
    chk16(pc_q, 16'h1234);
    chk16(sp_q, 16'h017e);
    cmd(`CFSR_CMD_RET, 16'h0000);
    chk16(pc_q, 16'habcd);
    cmd(`CFSR_CMD_SPRST, 16'h0000);
    chk16(sp_q, `CFSR_SP_RESET);
    // Request arrives while masked; it must wait for the mask to clear
    cmd(`CFSR_CMD_LD_X, 16'h0011);
    cmd(`CFSR_CMD_LD_Y, 16'h0022);
    cmd(`CFSR_CMD_LD_A, 16'h0033);
    cmd(`CFSR_CMD_LD_CC, 16'h0008);
    cmd(`CFSR_CMD_JUMP, 16'h2468);
    irq_req = 1'b1;
    tick();
    irq_req = 1'b0;
    repeat (3) tick();
    chk8({7'h00, irq_pend_q}, 8'h01);
    chk16(pc_q, 16'h2468);
    cmd(`CFSR_CMD_RIM, 16'h0000);
    for (i = 0; i < 20 && irq_ack_q !== 1'b1; i++) tick();
    chk8({7'h00, irq_ack_q}, 8'h01);
    wait_ready();
    chk16(pc_q, 16'h4000);
    chk8(cc_q, 8'he8);
    chk16(sp_q, 16'h017a);
    chk8(y_q, 8'h22);
    chk8({7'h00, irq_pend_q}, 8'h00);
    // Context comes back flags first, low address byte last
    for (i = 0; i < 5; i++) begin
      cmd(`CFSR_CMD_POP, 16'h0000);
      chk8(pop_data_q, ctx[i]);
      chk8({7'h00, pop_valid_q}, 8'h01);
    end
    chk16(sp_q, `CFSR_SP_RESET);
    // Trap is taken with the mask set; return clears the mask
    cmd(`CFSR_CMD_LD_A, 16'h0077);
    cmd(`CFSR_CMD_TRAP, 16'h5000);
    chk16(pc_q, 16'h5000);
    chk16(sp_q, 16'h017a);
    cmd(`CFSR_CMD_LD_A, 16'h0000);
    cmd(`CFSR_CMD_RETI, 16'h0000);
    chk8(acc_q, 8'h77);
    chk8(x_q, 8'h11);
    chk8(cc_q, 8'he0);
    chk16(pc_q, 16'h4000);
    chk16(sp_q, `CFSR_SP_RESET);
    results();
  end
endmodule
